// ---- hw/ds3i_defines.svh ----
// Purpose: Named offsets, bit positions, reset values and counts of the DS3
//          receive error and far-end message interrupt block.
// Assumes: Included by bare name from every design file that needs it.
// Notes:   Register indices are word indices; the byte address is four times.
`ifndef DS3I_DEFINES_SVH
`define DS3I_DEFINES_SVH

// ==========================================================================
// Register word indices and byte address mapping.
// ==========================================================================
`define DS3I_IDX_EN      6'h12
`define DS3I_IDX_STAT    6'h13
`define DS3I_IDX_CODE    6'h16
`define DS3I_IDX_CTRL    6'h17
`define DS3I_ALIGN       2'b00

// ==========================================================================
// Field positions.
// ==========================================================================
`define DS3I_PBIT        0
`define DS3I_CPBIT       7
`define DS3I_FV_STAT     0
`define DS3I_FV_EN       1
`define DS3I_FR_STAT     2
`define DS3I_FR_EN       3
`define DS3I_FVALID      4

// ==========================================================================
// Reset values and sizes.
// ==========================================================================
`define DS3I_RST_BYTE    8'h00
`define DS3I_RST_CODE    6'h00
`define DS3I_RST_WORD    32'h0000_0000
`define DS3I_FEAC_DEPTH  10
`define DS3I_FEAC_THRESH 8
`define DS3I_SEL_NONE    4'h0

`endif

// ---- hw/ds3i_pkg.sv ----
// Purpose: Shared types of the DS3 receive interrupt block.
// Assumes: Nothing beyond a SystemVerilog compiler.
// Notes:   Numeric constants live in ds3i_defines.svh.
package ds3i_pkg;
   // Eight-bit register image.
   typedef logic [7:0] ds3i_byte_t;
   // Six-bit far-end alarm and control code.
   typedef logic [5:0] ds3i_code_t;
   // Bus phase tracker, one-hot.
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b01,
      ST_ACCESS = 2'b10
   } ds3i_bus_e;
endpackage

// ---- hw/ds3i_feac_val.sv ----
// Purpose: Far-end message validator: a code is declared valid once it fills
//          enough of the most recent receptions.
// Assumes: One strobe per received message; code valid with the strobe.
// Notes:   A code equal to the one already validated raises no new pulse.
`timescale 1ns/1ps
`include "ds3i_defines.svh"
module ds3i_feac_val #(
   parameter int DEPTH  = `DS3I_FEAC_DEPTH,
   parameter int THRESH = `DS3I_FEAC_THRESH
) (
   input  wire logic             clock,      // System clock.
   input  wire logic             rstn,       // Synchronous reset, active low.
   input  wire logic             rx_strobe,  // One message received.
   input  wire ds3i_pkg::ds3i_code_t rx_code, // Code of that message.
   output logic                  new_valid,  // Pulse: new code validated.
   output ds3i_pkg::ds3i_code_t  valid_code  // Last validated code.
);
   import ds3i_pkg::*;
   localparam int CW = $clog2(DEPTH + 1);

   // ==========================================================================
   // History storage.
   // ==========================================================================
   ds3i_code_t       hist      [DEPTH];  // Newest reception at index 0.
   ds3i_code_t       next_hist [DEPTH];  // Next history contents.
   logic [DEPTH-1:0] hv;                 // Slot holds a real reception.
   logic [DEPTH-1:0] next_hv;            // Next slot occupancy.
   logic             have;               // Some code was validated before.
   logic             next_have;          // Next value of have.
   logic             next_new_valid;     // Next validation pulse.
   ds3i_code_t       next_valid_code;    // Next validated code.
   logic [CW-1:0]    votes;              // Matches in the new window.

   // Shift the window by one reception on each strobe.
   for (genvar i = 0; i < DEPTH; i++) begin : g_shift
      if (i == 0) begin : g_head
         assign next_hist[i] = rx_strobe ? rx_code : hist[i];
         assign next_hv[i]   = rx_strobe | hv[i];
      end else begin : g_body
         assign next_hist[i] = rx_strobe ? hist[i-1] : hist[i];
         assign next_hv[i]   = rx_strobe ? hv[i-1] : hv[i];
      end
   end

   // Count how many slots of the window after the shift hold this code.
   always_comb begin
      votes = CW'(1);
      for (int k = 0; k < DEPTH - 1; k++) begin
         if (hv[k] && hist[k] == rx_code) begin
            votes = CW'(votes + CW'(1));
         end
      end
   end

   // Declare a fresh code valid when the vote reaches the threshold.
   always_comb begin
      next_new_valid  = 1'b0;
      next_valid_code = valid_code;
      next_have       = have;
      if (rx_strobe && votes >= CW'(THRESH) &&
          (!have || rx_code != valid_code)) begin
         next_new_valid  = 1'b1;
         next_valid_code = rx_code;
         next_have       = 1'b1;
      end
   end

   // Register every value; the window empties on reset.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         for (int k = 0; k < DEPTH; k++) begin
            hist[k] <= `DS3I_RST_CODE;
         end
         hv         <= '0;
         have       <= 1'b0;
         new_valid  <= 1'b0;
         valid_code <= `DS3I_RST_CODE;
      end else begin
         hist       <= next_hist;
         hv         <= next_hv;
         have       <= next_have;
         new_valid  <= next_new_valid;
         valid_code <= next_valid_code;
      end
   end

   // ==========================================================================
   // Checks.
   // ==========================================================================
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   a_vote_before_valid: assert property (
      new_valid |-> $past(rx_strobe) && $past(votes) >= CW'(THRESH))
      else $error("Code validated without enough matching receptions.");
   a_valid_code_new: assert property (
      new_valid |-> valid_code == $past(rx_code) && valid_code != $past(valid_code)
                    || !$past(have))
      else $error("Validation pulse did not carry a fresh code.");
endmodule

// ---- hw/ds3i_rx_irq.sv ----
// Purpose: DS3 receive interrupt block: parity and CP-bit error interrupts and
//          far-end alarm and control message validation, behind an APB slave.
// Assumes: Error events are one-cycle pulses synchronous to clock.
// Notes:   The alarm interrupt pin is active high, the far-end message one is
//          active low, so the two sources leave on separate pins.
// Function
// - Enabled P-bit error: irq high, status bit0
// - Enabled CP-bit error raises an interrupt
// - Enable bit 7 gates the CP-bit interrupt
// - Enable bit one permits, zero suppresses
// - Enabled CP-bit error: irq high, status bit7
// - Message valid after 8 of last 10
// - Enabled new validated message raises an interrupt
// - Control bit 1 gates the validation interrupt
// - Enabled validation: irq pin low, control bit0 set
// - Validated six-bit code loads the message register
`timescale 1ns/1ps
`include "ds3i_defines.svh"
module ds3i_rx_irq #(
   parameter int FEAC_DEPTH  = `DS3I_FEAC_DEPTH,
   parameter int FEAC_THRESH = `DS3I_FEAC_THRESH
) (
   input  wire logic                 clock,          // 40 MHz system clock.
   input  wire logic                 rstn,           // Synchronous reset, low.
   input  wire logic                 psel,           // APB select.
   input  wire logic                 penable,        // APB access phase.
   input  wire logic                 pwrite,         // APB write when high.
   input  wire logic [7:0]           paddr,          // APB byte address.
   input  wire logic [31:0]          pwdata,         // APB write data.
   output logic [31:0]               prdata,         // APB read data.
   output logic                      pready,         // APB transfer done.
   output logic                      pslverr,        // APB unmapped address.
   input  wire ds3i_pkg::ds3i_byte_t rx_alarm_evt,   // Framer event pulses.
   input  wire logic                 feac_rx_strobe, // Far-end message seen.
   input  wire ds3i_pkg::ds3i_code_t feac_rx_code,   // Its six-bit code.
   output logic                      alarm_irq,      // Alarm interrupt, high.
   output logic                      far_end_irq_n   // Message interrupt, low.
);
   import ds3i_pkg::*;

   // ==========================================================================
   // Address decode.
   // ==========================================================================
   // Returns a one-hot select {ctrl, code, status, enable}; zero when the
   // address is unmapped or not word aligned.
   function automatic logic [3:0] reg_sel(input logic [7:0] addr);
      logic [3:0] sel;
      sel = `DS3I_SEL_NONE;
      if (addr[1:0] == `DS3I_ALIGN) begin
         case (addr[7:2])
            `DS3I_IDX_EN:   sel = 4'b0001;
            `DS3I_IDX_STAT: sel = 4'b0010;
            `DS3I_IDX_CODE: sel = 4'b0100;
            `DS3I_IDX_CTRL: sel = 4'b1000;
            default:        sel = `DS3I_SEL_NONE;
         endcase
      end
      return sel;
   endfunction

   // ==========================================================================
   // Declarations.
   // ==========================================================================
   ds3i_bus_e  state;            // Bus phase.
   ds3i_bus_e  next_state;       // Next bus phase.
   logic       setup;            // Setup cycle of a transfer.
   logic [3:0] sel;              // Decoded register of the current address.
   logic       wr_en;            // Write to the enable register.
   logic       wr_ctrl;          // Write to the message control register.
   logic       rd_stat;          // Read of the alarm status register ends.
   logic       rd_ctrl;          // Read of the message control register ends.
   ds3i_byte_t en;               // Alarm interrupt enables.
   ds3i_byte_t next_en;          // Next enables.
   ds3i_byte_t stat;             // Alarm interrupt status, read clears.
   ds3i_byte_t next_stat;        // Next status.
   logic       fv_en;            // Validation interrupt enable.
   logic       next_fv_en;       // Next validation enable.
   logic       fr_en;            // Removal interrupt enable, stored only.
   logic       next_fr_en;       // Next removal enable.
   logic       fv_stat;          // Validation interrupt status.
   logic       next_fv_stat;     // Next validation status.
   logic       fvalid;           // A validated message is held.
   logic       next_fvalid;      // Next held flag.
   ds3i_code_t code_reg;         // Last validated message code.
   ds3i_code_t next_code_reg;    // Next message code.
   logic       feac_new;         // Pulse from the validator.
   ds3i_code_t feac_code;        // Code from the validator.
   ds3i_byte_t rd_mux;           // Register image chosen at setup.
   logic [31:0] next_prdata;     // Next read data.
   logic       err;              // Current transfer is unmapped.
   logic       next_err;         // Next unmapped flag.
   logic       next_alarm_irq;   // Next alarm pin level.
   logic       next_far_end_irq_n; // Next message pin level.

   // ==========================================================================
   // Message validator.
   // ==========================================================================
   ds3i_feac_val #(
      .DEPTH  (FEAC_DEPTH),
      .THRESH (FEAC_THRESH)
   ) u_feac_val (
      .clock      (clock),
      .rstn       (rstn),
      .rx_strobe  (feac_rx_strobe),
      .rx_code    (feac_rx_code),
      .new_valid  (feac_new),
      .valid_code (feac_code)
   );

   // ==========================================================================
   // APB slave.
   // ==========================================================================
   // A transfer always completes on its first access cycle; the read image is
   // captured at the setup edge so that prdata comes from a flop.
   assign setup   = psel & ~penable;
   assign sel     = reg_sel(paddr);
   assign pready  = (state == ST_ACCESS) & psel & penable;
   assign pslverr = pready & err;
   assign wr_en   = pready & pwrite & sel[0];
   assign wr_ctrl = pready & pwrite & sel[3];
   assign rd_stat = pready & ~pwrite & sel[1];
   assign rd_ctrl = pready & ~pwrite & sel[3];

   // Bus phase: any setup cycle leads to an access phase.
   always_comb begin
      case (state)
         ST_IDLE:   next_state = setup ? ST_ACCESS : ST_IDLE;
         ST_ACCESS: next_state = setup ? ST_ACCESS : ST_IDLE;
         default:   next_state = ST_IDLE;
      endcase
   end

   // Register image for a read; reserved bits read as zero.
   always_comb begin
      case (sel)
         4'b0001: rd_mux = en;
         4'b0010: rd_mux = stat;
         4'b0100: rd_mux = {2'b00, code_reg};
         4'b1000: rd_mux = {3'b000, fvalid, fr_en, 1'b0, fv_en, fv_stat};
         default: rd_mux = `DS3I_RST_BYTE;
      endcase
   end

   // Read data and error flag are loaded at setup and held through access.
   always_comb begin
      next_prdata = prdata;
      next_err    = err;
      if (setup) begin
         next_prdata = pwrite ? `DS3I_RST_WORD : {24'h00_0000, rd_mux};
         next_err    = (sel == `DS3I_SEL_NONE);
      end
   end

   // ==========================================================================
   // Alarm enables and status.
   // ==========================================================================
   // Enables are plain read/write bits.
   always_comb begin
      next_en = wr_en ? pwdata[7:0] : en;
   end

   // Each status bit is set by its enabled event and cleared by a read that
   // returned it. Only bits that software actually saw are cleared, so an
   // event landing between setup and access is kept, and a set wins a clear.
   for (genvar i = 0; i < $bits(ds3i_byte_t); i++) begin : g_stat
      assign next_stat[i] = (stat[i] & ~(rd_stat & prdata[i]))
                          | (rx_alarm_evt[i] & en[i]);
   end

   // ==========================================================================
   // Far-end message control, status and code.
   // ==========================================================================
   // Enables follow writes; the status bit follows the validator pulse when
   // enabled. The code register loads on every validation, enabled or not.
   always_comb begin
      next_fv_en    = wr_ctrl ? pwdata[`DS3I_FV_EN] : fv_en;
      next_fr_en    = wr_ctrl ? pwdata[`DS3I_FR_EN] : fr_en;
      next_fv_stat  = (fv_stat & ~(rd_ctrl & prdata[`DS3I_FV_STAT]))
                    | (feac_new & fv_en);
      next_fvalid   = fvalid | feac_new;
      next_code_reg = feac_new ? feac_code : code_reg;
   end

   // ==========================================================================
   // Interrupt pins.
   // ==========================================================================
   // Pins are registered from the next state so they line up with status.
   always_comb begin
      next_alarm_irq     = |(next_stat & next_en);
      next_far_end_irq_n = ~(next_fv_stat & next_fv_en);
   end

   // ==========================================================================
   // State registers.
   // ==========================================================================
   always_ff @(posedge clock) begin
      if (!rstn) begin
         state         <= ST_IDLE;
         prdata        <= `DS3I_RST_WORD;
         err           <= 1'b0;
         en            <= `DS3I_RST_BYTE;
         stat          <= `DS3I_RST_BYTE;
         fv_en         <= 1'b0;
         fr_en         <= 1'b0;
         fv_stat       <= 1'b0;
         fvalid        <= 1'b0;
         code_reg      <= `DS3I_RST_CODE;
         alarm_irq     <= 1'b0;
         far_end_irq_n <= 1'b1;
      end else begin
         state         <= next_state;
         prdata        <= next_prdata;
         err           <= next_err;
         en            <= next_en;
         stat          <= next_stat;
         fv_en         <= next_fv_en;
         fr_en         <= next_fr_en;
         fv_stat       <= next_fv_stat;
         fvalid        <= next_fvalid;
         code_reg      <= next_code_reg;
         alarm_irq     <= next_alarm_irq;
         far_end_irq_n <= next_far_end_irq_n;
      end
   end

   // ==========================================================================
   // Checks.
   // ==========================================================================
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   a_pbit_status_set: assert property (
      rx_alarm_evt[`DS3I_PBIT] && en[`DS3I_PBIT] |=> stat[`DS3I_PBIT] && alarm_irq)
      else $error("P-bit error did not set status and raise the pin.");
   a_cpbit_raises_irq: assert property (
      rx_alarm_evt[`DS3I_CPBIT] && en[`DS3I_CPBIT] |=> alarm_irq)
      else $error("CP-bit error did not raise the alarm pin.");
   a_cpbit_gated_off: assert property (
      !en[`DS3I_CPBIT] && !stat[`DS3I_CPBIT] && !rd_stat |=> !stat[`DS3I_CPBIT])
      else $error("CP-bit status set while disabled.");
   a_enable_write: assert property (
      wr_en |=> en == $past(pwdata[7:0]))
      else $error("Enable register did not take written value.");
   a_cpbit_status_set: assert property (
      rx_alarm_evt[`DS3I_CPBIT] && en[`DS3I_CPBIT] |=> stat[`DS3I_CPBIT])
      else $error("CP-bit error did not set status bit 7.");
   a_feac_gated_off: assert property (
      !fv_en && !fv_stat |=> !fv_stat)
      else $error("Validation status set while disabled.");
   a_feac_pin_low: assert property (
      feac_new && fv_en |=> fv_stat && !far_end_irq_n)
      else $error("Validation did not set status and pull pin low.");
   a_feac_code_load: assert property (
      feac_new |=> code_reg == $past(feac_code)
                   ##1 (prdata[5:0] == code_reg || !$past(setup && sel[2])))
      else $error("Validated code not loaded.");
   a_read_clears_stat: assert property (
      rd_stat && ((rx_alarm_evt & en) == `DS3I_RST_BYTE)
      |=> (stat & $past(prdata[7:0])) == `DS3I_RST_BYTE)
      else $error("Status read did not clear returned bits.");
   a_irq_follows_stat: assert property (
      alarm_irq == |(stat & en))
      else $error("Alarm pin disagrees with enabled status.");
   a_stat_needs_en: assert property (
      ((stat & ~$past(stat)) & ~$past(en)) == `DS3I_RST_BYTE)
      else $error("Status bit set without its enable.");
   a_reset_clears: assert property (@(posedge clock) disable iff (1'b0)
      !rstn |=> stat == `DS3I_RST_BYTE && !fv_stat && !alarm_irq && far_end_irq_n)
      else $error("Reset did not clear status and pins.");

   c_pbit_irq:  cover property (rx_alarm_evt[`DS3I_PBIT] && en[`DS3I_PBIT] ##1 alarm_irq);
   c_cpbit_irq: cover property (rx_alarm_evt[`DS3I_CPBIT] && en[`DS3I_CPBIT] ##1 alarm_irq);
   c_feac_irq:  cover property (feac_new && fv_en ##1 !far_end_irq_n);
   c_stat_read: cover property (rd_stat && stat != `DS3I_RST_BYTE);
endmodule

// ---- dv/ds3i_host.sv ----
// Purpose: Host model: runs one APB transfer per go pulse and keeps the reply.
// Assumes: go is raised only while the model is idle.
// Notes:   Released address and data are inverted so no stale value lingers.
`timescale 1ns/1ps
module ds3i_host (
   input  wire logic        clock,                   // System clock.
   input  wire logic        rstn,                    // Synchronous reset, low.
   input  wire logic        go,                      // Start one transfer.
   input  wire logic        wr,                      // Write when high.
   input  wire logic [7:0]  addr,                    // Byte address.
   input  wire logic [31:0] wdata,                   // Write data.
   input  wire logic [31:0] prdata,                  // APB read data.
   input  wire logic        pready,                  // APB ready.
   input  wire logic        pslverr,                 // APB error.
   output logic             psel    = 1'b0,          // APB select.
   output logic             penable = 1'b0,          // APB access phase.
   output logic             pwrite  = 1'b0,          // APB direction.
   output logic [7:0]       paddr   = 8'h00,         // APB address.
   output logic [31:0]      pwdata  = 32'h0000_0000, // APB write data.
   output logic [31:0]      rdata   = 32'h0000_0000, // Data taken at the end.
   output logic             err     = 1'b0,          // Error taken at the end.
   output logic             done    = 1'b0           // Pulse: transfer over.
);
   // ==========
   // Bus phases.
   // ==========
   // The request is held until pready is seen high at a rising edge.
   always_ff @(posedge clock) begin
      done <= 1'b0;
      if (!rstn) begin
         psel    <= 1'b0;
         penable <= 1'b0;
      end else if (psel && penable && pready) begin
         rdata   <= prdata;
         err     <= pslverr;
         done    <= 1'b1;
         psel    <= 1'b0;
         penable <= 1'b0;
         paddr   <= ~paddr;
         pwdata  <= ~pwdata;
      end else if (psel) begin
         penable <= 1'b1;
      end else if (go) begin
         psel   <= 1'b1;
         pwrite <= wr;
         paddr  <= addr;
         pwdata <= wdata;
      end
   end
endmodule

// ---- dv/ds3i_rx_irq_tb.sv ----
// Purpose: Self-checking bench of the receive interrupt block.
// Assumes: Zero-wait APB slave; default validator depth and threshold.
// Notes:   Reset values are table rows; the event cases are written by hand.
`timescale 1ns/1ps
`include "ds3i_defines.svh"
module ds3i_rx_irq_tb;
   import ds3i_pkg::*;
   // ==========
   // Signals.
   // ==========
   localparam logic [7:0] A_EN = {`DS3I_IDX_EN, `DS3I_ALIGN};   // Enable.
   localparam logic [7:0] A_ST = {`DS3I_IDX_STAT, `DS3I_ALIGN}; // Status.
   localparam logic [7:0] A_CD = {`DS3I_IDX_CODE, `DS3I_ALIGN}; // Code.
   localparam logic [7:0] A_CT = {`DS3I_IDX_CTRL, `DS3I_ALIGN}; // Control.
   typedef struct {logic [7:0] a; logic [31:0] d; logic e;} ds3i_row_s;
   ds3i_row_s rows [6] = '{'{A_EN, 0, 0}, '{A_ST, 0, 0}, '{A_CD, 0, 0},
                           '{A_CT, 0, 0}, '{8'h00, 0, 1}, '{8'h49, 0, 1}};
   logic        clock = 1'b0;   // System clock.
   logic        rstn, go, wr;   // Reset and host request.
   logic [7:0]  addr, paddr;    // Request and bus address.
   logic [31:0] wdata, rdata;   // Host data.
   logic [31:0] pwdata, prdata; // Bus data.
   logic        psel, penable, pwrite, pready, pslverr, err, done;
   ds3i_byte_t  evt;            // Framer event pulses.
   logic        strobe;         // Message seen.
   ds3i_code_t  fcode;          // Message code.
   logic        alarm_irq, far_end_irq_n;
   int          n_mismatch = 0;
   int          comparisons = 0;
   // A 40 MHz clock.
   always #12.5 clock = ~clock;
   ds3i_rx_irq u_ds3i_rx_irq (.clock(clock), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_alarm_evt(evt),
      .feac_rx_strobe(strobe), .feac_rx_code(fcode), .alarm_irq(alarm_irq),
      .far_end_irq_n(far_end_irq_n));
   ds3i_host u_ds3i_host (.clock(clock), .rstn(rstn), .go(go), .wr(wr),
      .addr(addr), .wdata(wdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .rdata(rdata), .err(err), .done(done));
   // ==========
   // Tasks.
   // ==========
   // Prints the verdict and stops the run.
   task automatic tally_and_finish;
      if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Compares a register value.
   task automatic chk(input string what, input logic [31:0] exp, got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Compares an interrupt pin.
   task automatic chk_pin(input string what, input logic exp, got);
      chk(what, {31'h0, exp}, {31'h0, got});
   endtask
   // One transfer; the wait is bounded so a silent slave ends the run.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clock);
      go    <= 1'b1;
      wr    <= w;
      addr  <= a;
      wdata <= d;
      @(posedge clock);
      go <= 1'b0;
      for (i = 0; i < 20 && done !== 1'b1; i++) begin
         @(posedge clock);
         #1;
      end
      if (done !== 1'b1) begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask
   // Reads a register and compares it.
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(what, e, rdata);
   endtask
   // Lets n edges pass, then settles.
   task automatic idle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // One-cycle framer event; the status lands on the edge that sees it.
   task automatic pulse(input ds3i_byte_t e);
      @(posedge clock);
      evt <= e;
      @(posedge clock);
      evt <= 8'h00;
      #1;
   endtask
   // Sends n equal messages back to back, then allows the two-edge latency.
   task automatic send(input ds3i_code_t c, input int n);
      repeat (n) begin
         @(posedge clock);
         strobe <= 1'b1;
         fcode  <= c;
      end
      @(posedge clock);
      strobe <= 1'b0;
      idle(2);
   endtask
   // ==========
   // Sequence.
   // ==========
   initial begin
      rstn = 1'b0; go = 1'b0; wr = 1'b0; addr = 8'h00; wdata = 32'h0000_0000;
      evt = 8'h00; strobe = 1'b0; fcode = 6'h00;
      repeat (6) @(posedge clock);
      rstn <= 1'b1;
      #1;
      chk_pin("alarm_irq", 1'b0, alarm_irq);
      chk_pin("far_end_irq_n", 1'b1, far_end_irq_n);
      foreach (rows[k]) begin
         apb(1'b0, rows[k].a, 32'h0000_0000);
         chk("reset read", rows[k].d, rdata);
         chk_pin("pslverr", rows[k].e, err);
      end
      pulse(8'h81);
      chk_pin("alarm_irq", 1'b0, alarm_irq);
      rd_chk("status", A_ST, 32'h0000_0000);
      apb(1'b1, A_EN, 32'hFFFF_FF81);
      rd_chk("enable", A_EN, 32'h0000_0081);
      pulse(8'h01);
      chk_pin("alarm_irq", 1'b1, alarm_irq);
      pulse(8'h80);
      rd_chk("status", A_ST, 32'h0000_0081);
      idle(1);
      chk_pin("alarm_irq", 1'b0, alarm_irq);
      rd_chk("status", A_ST, 32'h0000_0000);
      apb(1'b1, A_EN, 32'h0000_0080);
      pulse(8'h81);
      chk_pin("alarm_irq", 1'b1, alarm_irq);
      rd_chk("status", A_ST, 32'h0000_0080);
      apb(1'b1, A_CT, 32'h0000_000A);
      send(6'h15, 7);
      chk_pin("far_end_irq_n", 1'b1, far_end_irq_n);
      send(6'h15, 1);
      chk_pin("far_end_irq_n", 1'b0, far_end_irq_n);
      rd_chk("code", A_CD, 32'h0000_0015);
      rd_chk("ctrl", A_CT, 32'h0000_001B);
      idle(1);
      chk_pin("far_end_irq_n", 1'b1, far_end_irq_n);
      rd_chk("ctrl", A_CT, 32'h0000_001A);
      send(6'h15, 3);
      chk_pin("far_end_irq_n", 1'b1, far_end_irq_n);
      send(6'h2A, 2);
      send(6'h07, 1);
      send(6'h2A, 5);
      chk_pin("far_end_irq_n", 1'b1, far_end_irq_n);
      send(6'h2A, 1);
      chk_pin("far_end_irq_n", 1'b0, far_end_irq_n);
      rd_chk("code", A_CD, 32'h0000_002A);
      rd_chk("ctrl", A_CT, 32'h0000_001B);
      apb(1'b1, A_CT, 32'h0000_0008);
      send(6'h0F, 8);
      chk_pin("far_end_irq_n", 1'b1, far_end_irq_n);
      rd_chk("ctrl", A_CT, 32'h0000_0018);
      rd_chk("code", A_CD, 32'h0000_000F);
      apb(1'b1, A_EN, 32'h0000_0001);
      pulse(8'h01);
      @(posedge clock);
      rstn <= 1'b0;
      @(posedge clock);
      rstn <= 1'b1;
      #1;
      chk_pin("alarm_irq", 1'b0, alarm_irq);
      rd_chk("enable", A_EN, 32'h0000_0000);
      rd_chk("code", A_CD, 32'h0000_0000);
      tally_and_finish();
   end
endmodule
